// ### design/pcg_pkg.sv
package pcg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_SMOOTH_TIME   = 10'h108;
    localparam logic [9:0]  IDX_NUMER_SECOND  = 10'h10F;
    localparam logic [9:0]  IDX_NUMER_FIRST   = 10'h12C;
    localparam logic [9:0]  IDX_DENOMINATOR   = 10'h12D;
    localparam logic [9:0]  IDX_CONTROL       = 10'h140;
    localparam logic [9:0]  IDX_STATUS        = 10'h141;
    localparam logic [9:0]  IDX_POSITION      = 10'h142;

    // Reset values
    localparam logic [15:0] RST_SMOOTH_TIME   = 16'h0000;
    localparam logic [15:0] RST_NUMERATOR     = 16'h0001;
    localparam logic [15:0] RST_DENOMINATOR   = 16'h0001;
    localparam logic        RST_SELECT_ENABLE = 1'b0;

    // Accepted ranges
    localparam logic [15:0] GEAR_MIN          = 16'h0001;
    localparam logic [15:0] GEAR_MAX          = 16'h7FFF;
    localparam logic [15:0] SMOOTH_MIN        = 16'h0000;
    localparam logic [15:0] SMOOTH_MAX        = 16'h03E8;
    localparam logic [31:0] RATIO_LOW_DIV     = 32'h0000_0032;
    localparam logic [31:0] RATIO_HIGH_MUL    = 32'h0000_00C8;

    // Field positions
    localparam int unsigned CTRL_SEL_EN_BIT   = 0;
    localparam int unsigned STAT_SECOND_BIT   = 0;
    localparam int unsigned STAT_RATIO_OK_BIT = 1;
    localparam int unsigned STAT_SEL_PIN_BIT  = 2;

    // Timing
    localparam int unsigned CLK_PERIOD_NS     = 32'h0000_0005;
    localparam int unsigned SAMPLE_TIME_NS    = 32'h0001_86A0;
    localparam int unsigned SMOOTH_UNIT_NS    = 32'h0098_9680;
    localparam int unsigned SAMPLE_CYCLES_DEF = SAMPLE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_UNIT    = SMOOTH_UNIT_NS / SAMPLE_TIME_NS;

    localparam int unsigned SYNC_STAGES       = 2;

endpackage

// ### design/pcg_gear_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_gear_scaler
    import pcg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        pulse,
    input  wire logic        dir_fwd,
    input  wire logic [15:0] numer,
    input  wire logic [15:0] denom,
    output logic             step_up,
    output logic             step_dn
);
    // Signed remainder carries the fraction between pulses
    logic signed [23:0] rem_r;
    logic signed [23:0] rem_nxt;
    logic signed [23:0] n_ext;
    logic signed [23:0] m_ext;
    logic signed [23:0] add;
    logic signed [23:0] sub;
    logic               dec_up;
    logic               dec_dn;

    assign n_ext   = signed'({8'h00, numer});
    assign m_ext   = signed'({8'h00, denom});
    assign dec_up  = rem_r >= m_ext;
    assign dec_dn  = rem_r <= -m_ext;
    assign add     = pulse ? (dir_fwd ? n_ext : -n_ext) : 24'sh00_0000; // R6
    assign sub     = dec_up ? m_ext : (dec_dn ? -m_ext : 24'sh00_0000);
    // One output count per cycle; a pulse can need up to 32767 cycles at the largest ratio
    assign rem_nxt = rem_r + add - sub; // R12

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rem_r   <= 24'sh00_0000;
            step_up <= 1'b0;
            step_dn <= 1'b0;
        end
        else
        begin
            rem_r   <= rem_nxt;
            step_up <= dec_up;
            step_dn <= dec_dn;
        end
    end
endmodule // pcg_gear_scaler
`default_nettype wire

// ### design/pcg_cmd_smoother.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_cmd_smoother
    import pcg_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        in_up,
    input  wire logic        in_dn,
    input  wire logic [15:0] smooth_time,
    output logic             out_up,
    output logic             out_dn,
    output logic [31:0]      filt_pos
);
    // Output moves at rate (target - output) / tau, one count per cycle
    logic signed [31:0] tgt_r;
    logic signed [31:0] err;
    logic signed [39:0] acc_r;
    logic signed [39:0] acc_nxt;
    logic signed [39:0] tau;
    logic [23:0]        tick_cnt_r;
    logic               tick;
    logic               bypass;
    logic               go_up;
    logic               go_dn;

    assign tau    = signed'(40'(smooth_time) * 40'(TICKS_PER_UNIT));
    assign bypass = smooth_time == SMOOTH_MIN; // R10
    assign err    = tgt_r - signed'(filt_pos);
    assign tick   = tick_cnt_r == 24'(SAMPLE_CYCLES - 1);
    assign go_up  = bypass ? (err > 0) : (acc_r >= tau); // R10
    assign go_dn  = bypass ? (err < 0) : (acc_r <= -tau); // R10
    assign acc_nxt = bypass ? 40'sh00_0000_0000
                   : acc_r + (tick ? 40'(err) : 40'sh00_0000_0000)
                     - (go_up ? tau : 40'sh00_0000_0000)
                     + (go_dn ? tau : 40'sh00_0000_0000);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tgt_r      <= 32'sh0000_0000;
            filt_pos   <= 32'h0000_0000;
            acc_r      <= 40'sh00_0000_0000;
            tick_cnt_r <= 24'h00_0000;
            out_up     <= 1'b0;
            out_dn     <= 1'b0;
        end
        else
        begin
            tgt_r      <= tgt_r + 32'(in_up) - 32'(in_dn);
            filt_pos   <= filt_pos + 32'(go_up) - 32'(go_dn);
            acc_r      <= acc_nxt;
            tick_cnt_r <= tick ? 24'h00_0000 : tick_cnt_r + 24'h00_0001;
            out_up     <= go_up;
            out_dn     <= go_dn;
        end
    end
endmodule // pcg_cmd_smoother
`default_nettype wire

// ### design/pcg_gear_top.sv
// Overview of operation
// R1: Second numerator register, writes 1 to 32767 accepted, resets to 1.
// R2: First numerator register, writes 1 to 32767 accepted, resets to 1.
// R3: Denominator register, writes 1 to 32767 accepted, resets to 1.
// R4: A digital input picks which numerator scales the command pulses.
// R5: With selection not assigned, only the first numerator is used.
// R6: Output command rate equals input rate times numerator over denominator.
// R7: Software keeps ratio above 1/50 and below 200.
// R8: Software changes the ratio only while the drive output is off.
// R9: Ratio changes are accepted while the drive output is on.
// R10: Smoothing filter, constant 0 to 1000 in 10 ms units, 0 bypasses.
// R11: Select low uses first numerator, high second, from next pulse.
// R12: Scaling remainder is kept so no pulses are lost or gained.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pcg_gear_top
    import pcg_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cmd_pulse_pin,
    input  wire logic        cmd_dir_pin,
    input  wire logic        numerator_select_input,
    output logic             pos_cmd_step,
    output logic             pos_cmd_dir
);

    function automatic logic in_range(
        input logic [15:0] v,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Pin synchronisers

    logic [2:0] pin_raw;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       pulse_d_r;

    assign pin_raw = {numerator_select_input, cmd_dir_pin, cmd_pulse_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end
                else
                begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_d_r <= 1'b0;
        end
        else
        begin
            pulse_d_r <= sync2_r[0];
        end
    end

    wire        pulse_rise = sync2_r[0] & ~pulse_d_r;
    wire        dir_fwd    = sync2_r[1];
    wire        sel_level  = sync2_r[2];

    // Registers

    logic [15:0] smooth_time_r;
    logic [15:0] numer_second_r;
    logic [15:0] numer_first_r;
    logic [15:0] denom_r;
    logic        sel_enable_r;

    // Bus slave: one wait cycle for every access

    wire        req       = avs_read | avs_write;
    wire        commit    = avs_write & ~avs_waitrequest;
    wire [9:0]  idx       = avs_address[11:2];
    wire [15:0] wdata16   = avs_writedata[15:0];

    wire        hit_smooth = idx == IDX_SMOOTH_TIME;
    wire        hit_second = idx == IDX_NUMER_SECOND;
    wire        hit_first  = idx == IDX_NUMER_FIRST;
    wire        hit_denom  = idx == IDX_DENOMINATOR;
    wire        hit_ctrl   = idx == IDX_CONTROL;
    wire        hit_status = idx == IDX_STATUS;
    wire        hit_pos    = idx == IDX_POSITION;

    // Out of range values are dropped, the old setting stays
    wire        wr_smooth = commit & hit_smooth & in_range(wdata16, SMOOTH_MIN, SMOOTH_MAX); // R10
    wire        wr_second = commit & hit_second & in_range(wdata16, GEAR_MIN, GEAR_MAX); // R1
    wire        wr_first  = commit & hit_first & in_range(wdata16, GEAR_MIN, GEAR_MAX); // R2
    wire        wr_denom  = commit & hit_denom & in_range(wdata16, GEAR_MIN, GEAR_MAX); // R3
    wire        wr_ctrl   = commit & hit_ctrl;

    // Numerator selection

    wire        use_second = sel_enable_r & sel_level; // R4 R5 R11
    wire [15:0] numer_sel  = use_second ? numer_second_r : numer_first_r; // R11

    // Ratio check for software; the block scales whatever is set
    wire [31:0] n32      = {16'h0000, numer_sel};
    wire [31:0] m32      = {16'h0000, denom_r};
    wire        ratio_ok = (n32 * RATIO_LOW_DIV > m32) && (n32 < m32 * RATIO_HIGH_MUL); // R7

    logic [31:0] filt_pos;

    wire [31:0] status_word =
        {29'h0000_0000, sel_level, ratio_ok, use_second};

    wire [31:0] rd_mux =
        hit_smooth ? {16'h0000, smooth_time_r} :
        hit_second ? {16'h0000, numer_second_r} :
        hit_first  ? {16'h0000, numer_first_r} :
        hit_denom  ? {16'h0000, denom_r} :
        hit_ctrl   ? {31'h0000_0000, sel_enable_r} :
        hit_status ? status_word :
        hit_pos    ? filt_pos :
        32'h0000_0000;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest)
            begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Writes take effect in any drive state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            smooth_time_r  <= RST_SMOOTH_TIME;
            numer_second_r <= RST_NUMERATOR;
            numer_first_r  <= RST_NUMERATOR;
            denom_r        <= RST_DENOMINATOR;
            sel_enable_r   <= RST_SELECT_ENABLE;
        end
        else
        begin
            if (wr_smooth)
            begin
                smooth_time_r <= wdata16; // R10
            end
            if (wr_second)
            begin
                numer_second_r <= wdata16; // R1 R9
            end
            if (wr_first)
            begin
                numer_first_r <= wdata16; // R2 R9
            end
            if (wr_denom)
            begin
                denom_r <= wdata16; // R3 R9
            end
            if (wr_ctrl)
            begin
                sel_enable_r <= avs_writedata[CTRL_SEL_EN_BIT]; // R5
            end
        end
    end

    // Scaling and smoothing

    logic sc_up;
    logic sc_dn;
    logic sm_up;
    logic sm_dn;

    pcg_gear_scaler u_scaler (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pulse   (pulse_rise),
        .dir_fwd (dir_fwd),
        .numer   (numer_sel),
        .denom   (denom_r),
        .step_up (sc_up),
        .step_dn (sc_dn)
    );

    pcg_cmd_smoother #(
        .SAMPLE_CYCLES (SAMPLE_CYCLES)
    ) u_smoother (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .in_up       (sc_up),
        .in_dn       (sc_dn),
        .smooth_time (smooth_time_r),
        .out_up      (sm_up),
        .out_dn      (sm_dn),
        .filt_pos    (filt_pos)
    );

    // Direction holds its last value between steps
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pos_cmd_step <= 1'b0;
            pos_cmd_dir  <= 1'b1;
        end
        else
        begin
            pos_cmd_step <= sm_up | sm_dn; // R6
            if (sm_up | sm_dn)
            begin
                pos_cmd_dir <= sm_up;
            end
        end
    end

endmodule // pcg_gear_top
`default_nettype wire

// ### tb/pcg_gear_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_gear_top_properties
    import pcg_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [11:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cmd_pulse_pin,
    input wire logic        cmd_dir_pin,
    input wire logic        numerator_select_input,
    input wire logic        pos_cmd_step,
    input wire logic        pos_cmd_dir
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    property p_wait_ans;
        s_req |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("access not answered");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("ack longer than one cycle");
    property p_wait_idle;
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("ack without request");
    property p_ack_cause;
        !avs_waitrequest |-> $past(avs_read) || $past(avs_write);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack with no prior request");
    // Read data may only move in the cycle that answers a read
    property p_rd_hold;
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_rd_unmapped;
        s_rd_done and (avs_address == 12'h000) |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_upper;
        s_rd_done and (avs_address != 12'h508) |-> avs_readdata[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    property p_dir_step;
        $changed(pos_cmd_dir) |-> pos_cmd_step;
    endproperty
    a_dir_step: assert property (p_dir_step) else $error("direction moved alone");
endmodule // pcg_gear_top_properties

bind pcg_gear_top pcg_gear_top_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    u_pcg_gear_top_properties (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_pulse_pin(cmd_pulse_pin), .cmd_dir_pin(cmd_dir_pin),
    .numerator_select_input(numerator_select_input), .pos_cmd_step(pos_cmd_step),
    .pos_cmd_dir(pos_cmd_dir));
`default_nettype wire

// ### tb/pcg_pulse_source.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_pulse_source
(
    input  wire logic sys_clk,
    output logic      pulse_pin,
    output logic      dir_pin
);
    initial
    begin
        pulse_pin = 1'b0;
        dir_pin   = 1'b1;
    end
    // Direction settles before the first edge; gap of 2 is the fastest legal rate
    task automatic send(input int n, input logic fwd, input int gap);
        dir_pin <= fwd;
        repeat (3) @(posedge sys_clk);
        repeat (n)
        begin
            pulse_pin <= 1'b1;
            repeat (gap) @(posedge sys_clk);
            pulse_pin <= 1'b0;
            repeat (gap) @(posedge sys_clk);
        end
    endtask
endmodule // pcg_pulse_source
`default_nettype wire

// ### tb/pcg_gear_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module pcg_gear_top_test;
    logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest, sel;
    logic        cmd_pulse_pin, cmd_dir_pin, pos_cmd_step, pos_cmd_dir;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, cnt, base, q;
    logic [11:0] gear [3] = '{12'h43C, 12'h4B0, 12'h4B4};
    int          error_cnt = 0;
    int          total_checks = 0;

    pcg_gear_top #(.SAMPLE_CYCLES(20)) u_pcg_gear_top (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_pulse_pin(cmd_pulse_pin),
        .cmd_dir_pin(cmd_dir_pin), .numerator_select_input(sel),
        .pos_cmd_step(pos_cmd_step), .pos_cmd_dir(pos_cmd_dir));
    pcg_pulse_source u_pcg_pulse_source (.sys_clk(sys_clk), .pulse_pin(cmd_pulse_pin),
        .dir_pin(cmd_dir_pin));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Net output position, counted from the step and direction outputs
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            cnt <= 32'h0000_0000;
        else if (pos_cmd_step)
            cnt <= pos_cmd_dir ? cnt + 32'h0000_0001 : cnt - 32'h0000_0001;

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask
    task automatic run(input int n, input logic fwd, input int gap);
        u_pcg_pulse_source.send(n, fwd, gap);
        repeat (40) @(posedge sys_clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 12'h000;
        avs_writedata = 32'h0000_0000;
        sel = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h420, 32'h0000_0000);
        rd(12'h43C, 32'h0000_0001);
        rd(12'h4B0, 32'h0000_0001);
        rd(12'h4B4, 32'h0000_0001);
        rd(12'h500, 32'h0000_0000);
        rd(12'h000, 32'h0000_0000);
        $display("test reset values done");
        foreach (gear[i])
        begin
            wr(gear[i], 32'h0000_0000);
            rd(gear[i], 32'h0000_0001);
            wr(gear[i], 32'h0000_8000);
            rd(gear[i], 32'h0000_0001);
            wr(gear[i], 32'h0000_7FFF);
            rd(gear[i], 32'h0000_7FFF);
        end
        wr(12'h420, 32'h0000_03E9);
        rd(12'h420, 32'h0000_0000);
        wr(12'h420, 32'h0000_03E8);
        rd(12'h420, 32'h0000_03E8);
        wr(12'h420, 32'h0000_0000);
        $display("test ranges done");
        wr(12'h4B0, 32'h0000_0003);
        wr(12'h4B4, 32'h0000_0002);
        wr(12'h43C, 32'h0000_0001);
        rd(12'h504, 32'h0000_0002);
        run(5, 1'b1, 2);
        run(5, 1'b1, 8);
        `CHK(cnt, 32'h0000_000F)
        $display("test scaling done");
        sel <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(12'h504, 32'h0000_0006);
        run(4, 1'b1, 2);
        `CHK(cnt, 32'h0000_0015)
        wr(12'h500, 32'h0000_0001);
        acc(1'b0, 12'h504, 32'h0000_0000);
        `CHK(q & 32'h0000_0005, 32'h0000_0005)
        run(4, 1'b1, 2);
        `CHK(cnt, 32'h0000_0017)
        run(6, 1'b0, 2);
        `CHK(cnt, 32'h0000_0014)
        `CHK(pos_cmd_dir, 1'b0)
        sel <= 1'b0;
        repeat (4) @(posedge sys_clk);
        run(2, 1'b1, 3);
        `CHK(cnt, 32'h0000_0017)
        rd(12'h508, 32'h0000_0017);
        $display("test selection done");
        wr(12'h4B0, 32'h0000_00C8);
        wr(12'h4B4, 32'h0000_0001);
        acc(1'b0, 12'h504, 32'h0000_0000);
        `CHK(q[1], 1'b0)
        wr(12'h4B0, 32'h0000_0001);
        wr(12'h420, 32'h0000_0001);
        base = cnt;
        u_pcg_pulse_source.send(8, 1'b1, 2);
        repeat (20) @(posedge sys_clk);
        `CHK((cnt - base) < 32'h0000_0008, 1'b1)
        $display("test smoothing done");
        conclude();
    end
endmodule // pcg_gear_top_test
`default_nettype wire
